// ===== design/fifo_array_ctrl.sv
// Overview of operation
// - new input only after last slave full low; extract only when empty high
// - row master serial-input enable tied low; slaves chain from neighbour full
// - a master reset pulse must follow power-up before any operation
// - push-to-stack is best driven straight from the device's own input-full; here it is a registered copy of the synchronised full
`timescale 1ns/1ps
module fifo_array_ctrl
	import fifo_ctrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	// user write side
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [fifo_ctrl_pkg::WORD_W-1:0] wr_data,
	// user read side
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [fifo_ctrl_pkg::WORD_W-1:0] rd_data,
	// array pins
	output logic master_reset_n,
	output logic serial_in_enable_n,
	output logic serial_out_enable_n,
	output logic parallel_load,
	output logic [fifo_ctrl_pkg::WORD_W-1:0] load_data,
	output logic push_to_stack_n,
	output logic shift_in_clock_n,
	output logic pull_parallel,
	output logic pull_serial_n,
	output logic shift_out_clock_n,
	input wire logic input_full_n,
	input wire logic output_empty_n,
	input wire logic [fifo_ctrl_pkg::WORD_W-1:0] read_data
);
	import fifo_ctrl_pkg::*;

	typedef struct packed {
		init_t init;
		in_t in_st;
		out_t out_st;
		logic [3:0] init_cnt;
		logic [3:0] in_cnt;
		logic [3:0] out_cnt;
		logic mr_n;
		logic load;
		logic [WORD_W-1:0] ld_data;
		logic push_n;
		logic pull;
		logic [1:0] full_sy;
		logic [1:0] empty_sy;
		logic [WORD_W-1:0] rd_sy1;
		logic [WORD_W-1:0] rd_sy2;
	} ctrl_t;

	ctrl_t st_r;
	ctrl_t st_nxt;
	logic full_s;
	logic empty_s;
	logic running;
	logic buf_in_ready;
	logic cap_valid;

	assign full_s = st_r.full_sy[1];
	assign empty_s = st_r.empty_sy[1];
	assign running = (st_r.init == INIT_DONE);
	assign wr_ready = running && (st_r.in_st == IN_IDLE);
	// capture holds until the buffer takes it: only armed, with the last slave showing data held
	assign cap_valid = running && (st_r.out_st == OUT_ARM) && empty_s;

	// this controller is the row master's neighbour: its enables stay grounded
	assign serial_in_enable_n = 1'b0;
	assign serial_out_enable_n = 1'b0;
	// parallel mode only: serial strobes parked low as the device expects
	assign shift_in_clock_n = 1'b0;
	assign pull_serial_n = 1'b0;
	assign shift_out_clock_n = 1'b0;
	assign master_reset_n = st_r.mr_n;
	assign parallel_load = st_r.load;
	assign load_data = st_r.ld_data;
	assign push_to_stack_n = st_r.push_n;
	assign pull_parallel = st_r.pull;

	always_comb begin
		st_nxt = st_r;
		st_nxt.full_sy = {st_r.full_sy[0], input_full_n};
		st_nxt.empty_sy = {st_r.empty_sy[0], output_empty_n};
		st_nxt.rd_sy1 = read_data;
		st_nxt.rd_sy2 = st_r.rd_sy1;
		// automatic transfer: each completed word is pushed one cycle after the synchronised full falls
		st_nxt.push_n = full_s || !running;

		unique case (st_r.init)
			INIT_PULSE: begin
				st_nxt.mr_n = 1'b0;
				if (st_r.init_cnt >= MR_PULSE_CYC - CNT_ONE) begin
					st_nxt.init = INIT_RECOVER;
					st_nxt.init_cnt = CNT_ZERO;
					st_nxt.mr_n = 1'b1;
				end else
					st_nxt.init_cnt = st_r.init_cnt + CNT_ONE;
			end
			INIT_RECOVER: begin
				if (st_r.init_cnt >= MR_RECOVER_CYC - CNT_ONE)
					st_nxt.init = INIT_DONE;
				else
					st_nxt.init_cnt = st_r.init_cnt + CNT_ONE;
			end
			INIT_DONE: ;
			default: st_nxt.init = INIT_PULSE;
		endcase

		unique case (st_r.in_st)
			IN_IDLE: begin
				if (wr_valid && wr_ready) begin
					st_nxt.in_st = IN_LOAD;
					st_nxt.load = 1'b1;
					st_nxt.ld_data = wr_data;
					st_nxt.in_cnt = CNT_ZERO;
				end
			end
			IN_LOAD: begin
				if (st_r.in_cnt >= LOAD_HIGH_CYC - CNT_ONE) begin
					st_nxt.load = 1'b0;
					st_nxt.in_st = IN_WAIT_FULL;
				end else
					st_nxt.in_cnt = st_r.in_cnt + CNT_ONE;
			end
			// last slave full low: the whole row has taken the word
			IN_WAIT_FULL: begin
				if (!full_s)
					st_nxt.in_st = IN_WAIT_INIT;
			end
			// full stays low while the stack is full, so this is the stall point
			IN_WAIT_INIT: begin
				if (full_s)
					st_nxt.in_st = IN_IDLE;
			end
		endcase

		unique case (st_r.out_st)
			OUT_ARM: begin
				if (cap_valid && buf_in_ready) begin
					st_nxt.pull = 1'b0;
					st_nxt.out_cnt = CNT_ZERO;
					st_nxt.out_st = OUT_RELEASE;
				end else
					st_nxt.pull = running;
			end
			OUT_RELEASE: begin
				if (st_r.out_cnt >= PULL_LOW_CYC - CNT_ONE) begin
					if (!empty_s) begin
						st_nxt.pull = 1'b1;
						st_nxt.out_cnt = CNT_ZERO;
						st_nxt.out_st = OUT_REARM;
					end
				end else
					st_nxt.out_cnt = st_r.out_cnt + CNT_ONE;
			end
			// a high pulse shorter than the minimum could miss the next word
			OUT_REARM: begin
				if (st_r.out_cnt >= PULL_HIGH_CYC - CNT_ONE)
					st_nxt.out_st = OUT_ARM;
				else
					st_nxt.out_cnt = st_r.out_cnt + CNT_ONE;
			end
			default: st_nxt.out_st = OUT_ARM;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.init <= INIT_PULSE;
			st_r.in_st <= IN_IDLE;
			st_r.out_st <= OUT_ARM;
			st_r.push_n <= 1'b1;
			st_r.full_sy <= 2'h3;
		end else
			st_r <= st_nxt;
	end

	word_buffer u_buf (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(cap_valid && (st_r.out_st == OUT_ARM)),
		.in_ready(buf_in_ready),
		.in_data(st_r.rd_sy2),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	reset_first_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(master_reset_n) |-> !$past(master_reset_n, 2))
		else $error("master reset pulse shorter than minimum");
	no_op_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		!master_reset_n |-> !wr_ready && !parallel_load && !pull_parallel)
		else $error("array driven during master reset");
	master_tie_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		running |-> !serial_in_enable_n && !serial_out_enable_n)
		else $error("row master enable not grounded");
	push_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		running && $fell(full_s) |=> !push_to_stack_n)
		else $error("push did not follow input full");
	load_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		wr_valid && wr_ready |=> parallel_load [*3] ##1 !parallel_load ##0 !wr_ready)
		else $error("parallel load pulse wrong");
	load_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$fell(parallel_load) |-> !wr_ready throughout (##[0:1000] !full_s))
		else $error("new input before row full");
	pull_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$fell(pull_parallel) && running |-> $past(empty_s))
		else $error("extraction without output data");
endmodule : fifo_array_ctrl

// ===== design/fifo_ctrl_pkg.sv
package fifo_ctrl_pkg;
	localparam int WORD_W = 4;
	localparam int CLK_NS = 10;
	// least times round up to whole cycles
	localparam int MR_PULSE_NS = 15;
	localparam logic [3:0] MR_PULSE_CYC = 4'((MR_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam int MR_RECOVER_NS = 5;
	localparam logic [3:0] MR_RECOVER_CYC = 4'((MR_RECOVER_NS + CLK_NS - 1) / CLK_NS);
	localparam int LOAD_HIGH_NS = 30;
	localparam logic [3:0] LOAD_HIGH_CYC = 4'((LOAD_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam int PULL_LOW_NS = 25;
	localparam logic [3:0] PULL_LOW_CYC = 4'((PULL_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam int PULL_HIGH_NS = 17;
	localparam logic [3:0] PULL_HIGH_CYC = 4'((PULL_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam int BUF_DEPTH = 2;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;

	typedef enum logic [1:0] {INIT_PULSE, INIT_RECOVER, INIT_DONE} init_t;
	typedef enum logic [1:0] {IN_IDLE, IN_LOAD, IN_WAIT_FULL, IN_WAIT_INIT} in_t;
	typedef enum logic [1:0] {OUT_ARM, OUT_RELEASE, OUT_REARM} out_t;
endpackage : fifo_ctrl_pkg

// ===== design/word_buffer.sv
`timescale 1ns/1ps
module word_buffer
	import fifo_ctrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [fifo_ctrl_pkg::WORD_W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [fifo_ctrl_pkg::WORD_W-1:0] out_data
);
	import fifo_ctrl_pkg::*;

	typedef struct packed {
		logic [BUF_DEPTH-1:0][WORD_W-1:0] mem;
		logic wr_idx;
		logic rd_idx;
		logic [1:0] count;
	} buf_t;

	buf_t st_r;
	buf_t st_nxt;
	logic do_in;
	logic do_out;

	assign in_ready = (st_r.count != 2'(BUF_DEPTH));
	assign out_valid = (st_r.count != 2'h0);
	assign out_data = st_r.mem[st_r.rd_idx];
	assign do_in = in_valid && in_ready;
	assign do_out = out_valid && out_ready;

	always_comb begin
		st_nxt = st_r;
		if (do_in) begin
			st_nxt.mem[st_r.wr_idx] = in_data;
			st_nxt.wr_idx = ~st_r.wr_idx;
		end
		if (do_out)
			st_nxt.rd_idx = ~st_r.rd_idx;
		if (do_in && !do_out)
			st_nxt.count = st_r.count + 2'h1;
		else if (!do_in && do_out)
			st_nxt.count = st_r.count - 2'h1;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
endmodule : word_buffer

// ===== sim/fifo_dev_model.sv
`timescale 1ns/1ps
module fifo_dev_model
	import fifo_ctrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic master_reset_n,
	input wire logic serial_in_enable_n,
	input wire logic serial_out_enable_n,
	input wire logic parallel_load,
	input wire logic [fifo_ctrl_pkg::WORD_W-1:0] load_data,
	input wire logic push_to_stack_n,
	input wire logic pull_parallel,
	input wire logic slow,
	output logic input_full_n = 1'h1,
	output logic output_empty_n = 1'h0,
	output logic [fifo_ctrl_pkg::WORD_W-1:0] read_data = 4'h0
);
	localparam int STACK_WORDS = 14;
	logic [WORD_W-1:0] stk[$];
	logic [WORD_W-1:0] in_w = 4'h0;
	logic in_f = 1'h0;
	logic req = 1'h0;
	logic mst = 1'h0;
	logic out_f = 1'h0;
	int dly = 0;
	always @(posedge clk_sys) begin
		if (dly > 0)
			dly--;
		if (!master_reset_n) begin
			stk.delete();
			in_f = 1'h0;
			req = 1'h0;
			out_f = 1'h0;
			mst = !serial_in_enable_n;
		end else begin
			// full is flagged once a whole word stands in the input register
			if (parallel_load) begin
				in_w = load_data;
				in_f = 1'h1;
			end
			if (!push_to_stack_n && in_f)
				req = 1'h1;
			// slave waits for its neighbour; a full stack blocks the word in place
			if (req && !parallel_load && (mst || !serial_in_enable_n)
				&& stk.size() < STACK_WORDS && dly == 0) begin
				stk.push_back(in_w);
				in_f = 1'h0;
				req = 1'h0;
				dly = slow ? 6 : 0;
			end
			if (!pull_parallel)
				out_f = 1'h0;
			else if (!out_f && stk.size() > 0 && dly == 0) begin
				read_data <= stk.pop_front();
				out_f = 1'h1;
			end
		end
		input_full_n <= !(in_f && (mst || !serial_in_enable_n));
		// high means a word is held for the reader
		output_empty_n <= out_f && (mst || !serial_out_enable_n);
	end
endmodule : fifo_dev_model

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
	import fifo_ctrl_pkg::*;
	logic clk_sys = 1'h0;
	logic nrst = 1'h0;
	logic wr_valid = 1'h0;
	logic rd_ready = 1'h0;
	logic slow = 1'h0;
	logic [WORD_W-1:0] wr_data = 4'h0;
	logic [WORD_W-1:0] rd_data, load_data, read_data;
	logic wr_ready, rd_valid, master_reset_n, serial_in_enable_n, serial_out_enable_n;
	logic parallel_load, push_to_stack_n, pull_parallel, input_full_n, output_empty_n;
	logic shift_in_clock_n, pull_serial_n, shift_out_clock_n;
	int miscompares = 0;
	int n_checks = 0;
	always #(CLK_NS / 2) clk_sys = ~clk_sys;
	fifo_array_ctrl i_fifo_array_ctrl(.clk_sys, .nrst, .wr_valid, .wr_ready, .wr_data,
		.rd_valid, .rd_ready, .rd_data, .master_reset_n, .serial_in_enable_n,
		.serial_out_enable_n, .parallel_load, .load_data, .push_to_stack_n,
		.shift_in_clock_n, .pull_parallel, .pull_serial_n, .shift_out_clock_n,
		.input_full_n, .output_empty_n, .read_data);
	fifo_dev_model i_fifo_dev_model(.clk_sys, .master_reset_n, .serial_in_enable_n,
		.serial_out_enable_n, .parallel_load, .load_data, .push_to_stack_n, .pull_parallel,
		.slow, .input_full_n, .output_empty_n, .read_data);
	task automatic check_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : check_bit
	task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check_val
	task automatic complete_run();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic do_reset();
		@(negedge clk_sys);
		nrst = 1'h0;
		repeat (12) @(negedge clk_sys);
		check_bit(master_reset_n, 1'h0, "array reset held");
		check_bit(wr_ready, 1'h0, "no take in reset");
		nrst = 1'h1;
		@(negedge clk_sys);
		check_bit(master_reset_n, 1'h0, "array reset pulse");
		for (int i = 0; i < 20 && !wr_ready; i++) @(negedge clk_sys);
		check_bit(master_reset_n, 1'h1, "array reset ended");
		check_bit(wr_ready, 1'h1, "ready after init");
		check_bit(serial_in_enable_n, 1'h0, "row master tie");
		check_val({4'h0, serial_out_enable_n, shift_in_clock_n, pull_serial_n,
			shift_out_clock_n}, 8'h00, "serial pins parked");
	endtask : do_reset
	task automatic put(input logic [WORD_W-1:0] w, output bit ok);
		wr_data = w;
		wr_valid = 1'h1;
		for (int i = 0; i < 200 && !wr_ready; i++) @(negedge clk_sys);
		ok = wr_ready;
		if (!ok)
			wr_valid = 1'h0;
		@(negedge clk_sys);
		wr_valid = 1'h0;
		@(negedge clk_sys);
	endtask : put
	task automatic get(input logic [WORD_W-1:0] exp);
		for (int i = 0; i < 300 && !rd_valid; i++) @(negedge clk_sys);
		check_bit(rd_valid, 1'h1, "word out");
		check_val({4'h0, rd_data}, {4'h0, exp}, "word order");
		rd_ready = 1'h1;
		@(negedge clk_sys);
		rd_ready = 1'h0;
		@(negedge clk_sys);
	endtask : get
	// reader stalls until every stage is full, so the refusal is seen
	task automatic fill_drain();
		bit ok;
		int n;
		n = 0;
		ok = 1'h1;
		while (ok && n < 24) begin
			put(n[3:0], ok);
			if (ok)
				n++;
		end
		check_val(n[7:0], 8'h12, "words held");
		for (int k = 0; k < n; k++) get(k[3:0]);
		check_bit(rd_valid, 1'h0, "drained");
	endtask : fill_drain
	task automatic slow_stream();
		slow = 1'h1;
		fork
			for (int k = 0; k < 6; k++) begin
				bit ok;
				put(4'h5 + k[3:0], ok);
				check_bit(ok, 1'h1, "slow take");
			end
			for (int k = 0; k < 6; k++) get(4'h5 + k[3:0]);
		join
		slow = 1'h0;
	endtask : slow_stream
	task automatic reset_midrun();
		bit ok;
		put(4'h9, ok);
		put(4'h3, ok);
		do_reset();
		check_bit(rd_valid, 1'h0, "flushed");
		put(4'hc, ok);
		get(4'hc);
	endtask : reset_midrun
	initial begin
		#(60000 * CLK_NS);
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		do_reset();
		fill_drain();
		slow_stream();
		reset_midrun();
		complete_run();
	end
endmodule : tb
